/* File: logic/pwc_pkg.sv */
/*
 * pwc_pkg: constants, field layout and request carrier of the pulse width capture timer.
 * Assumes a byte-wide memory-mapped port driven by the local processor core.
 */
package pwc_pkg;

	// main clock rate, count clock is derived from it
	localparam int          CLK_PERIOD_NS = 100;
	localparam int          CLK_FREQ_HZ   = 1000000000 / CLK_PERIOD_NS;

	localparam int          ADDR_W        = 16;
	localparam int          DATA_W        = 8;
	localparam int          DIV_W         = 9;

	// register addresses
	localparam logic [15:0] CTRL_ADDR     = 16'hff58;
	localparam logic [15:0] RISE_ADDR     = 16'hff59;
	localparam logic [15:0] FALL_ADDR     = 16'hff5a;
	localparam logic [15:0] CNT_ADDR      = 16'hff5b;

	// count_control layout
	localparam logic [2:0]  CE_BIT        = 3'h7;
	localparam logic [2:0]  SEL_HI_BIT    = 3'h1;
	localparam logic [2:0]  SEL_LO_BIT    = 3'h0;
	localparam logic [7:0]  CTRL_WMASK    = 8'h83;
	localparam logic [7:0]  CTRL_RESET    = 8'h00;
	localparam logic [7:0]  CAP_RESET     = 8'h00;
	localparam logic [7:0]  CNT_RESET     = 8'h00;
	localparam logic [7:0]  UNMAPPED_DATA = 8'h00;

	// divider masks: count tick when the low bits of the divider are all ones
	localparam logic [8:0]  MASK_DIV512   = 9'h1ff;
	localparam logic [8:0]  MASK_DIV256   = 9'h0ff;
	localparam logic [8:0]  MASK_DIV128   = 9'h07f;
	localparam logic [8:0]  MASK_DIV64    = 9'h03f;

	// least spacing of two count ticks in main clocks
	localparam int          MIN_TICK_GAP  = 64;

	typedef enum logic [1:0] {
		PWC_SEL_DIV512,
		PWC_SEL_DIV256,
		PWC_SEL_DIV128,
		PWC_SEL_DIV64
	} pwc_sel_e;

	typedef struct packed {
		logic              rd;
		logic              wr;
		logic              bit_wr;
		logic [15:0]       addr;
		logic [2:0]        bit_idx;
		logic              bit_val;
		logic [7:0]        wdata;
	} pwc_req_s;

	typedef struct packed {
		logic              rise;
		logic              fall;
	} pwc_edge_s;

	function automatic logic [8:0] pwc_div_mask(input logic [1:0] sel);
		logic [8:0] m;
		m = MASK_DIV512;
		unique case (pwc_sel_e'(sel))
			PWC_SEL_DIV512: m = MASK_DIV512;
			PWC_SEL_DIV256: m = MASK_DIV256;
			PWC_SEL_DIV128: m = MASK_DIV128;
			PWC_SEL_DIV64:  m = MASK_DIV64;
		endcase
		return m;
	endfunction : pwc_div_mask

endpackage : pwc_pkg

/* File: logic/pwc_prescale.sv */
/*
 * pwc_prescale: free-running main clock divider producing the selected count tick.
 * Assumes clk is the main system clock and sel comes from the control register.
 */
`timescale 1ns/1ns
module pwc_prescale
	import pwc_pkg::*;
#(
	parameter int W = DIV_W
) (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	input  wire logic [1:0] sel,
	output logic            tick
);

	logic [W-1:0] div_q;
	logic [W-1:0] div_d;
	logic         tick_q;
	logic         tick_d;

	always_comb begin
		div_d  = div_q + W'(1);
		tick_d = (div_q & pwc_div_mask(sel)) == pwc_div_mask(sel); // R7
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else if (clk_en) begin
			div_q  <= div_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

	AST_TICK_GAP: assert property (@(posedge clk) disable iff (!reset_n) // R7
		tick && clk_en |=> !tick [*8])
		else $error("count tick repeated too soon");

endmodule : pwc_prescale

/* File: logic/pwc_edge_filter.sv */
/*
 * pwc_edge_filter: synchronises the pulse input pin and qualifies its edges.
 * Assumes tick is one main clock long per count clock period.
 */
`timescale 1ns/1ns
module pwc_edge_filter
	import pwc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	input  wire logic       tick,
	input  wire logic       pulse_input_pin,
	output pwc_edge_s       edge_o
);

	logic      sync1_q, sync2_q, sync3_q;
	logic      pin_q,   pin_d;
	logic      phase_q, phase_d;
	logic      samp_q,  samp_d;
	logic      level_q, level_d;
	pwc_edge_s edge_q,  edge_d;

	always_comb begin
		pin_d   = (sync2_q == sync3_q) ? sync3_q : pin_q; // R15
		phase_d = phase_q;
		samp_d  = samp_q;
		level_d = level_q;
		edge_d  = '0;
		if (tick) begin
			phase_d = !phase_q;
			// sample once every two count clocks
			if (phase_q) begin // R10
				samp_d = pin_q;
				// accept a new level only after two equal samples
				if (pin_q == samp_q && pin_q != level_q) begin // R10 R12
					level_d     = pin_q;
					edge_d.rise = pin_q;
					edge_d.fall = !pin_q;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			pin_q   <= 1'b0;
			phase_q <= 1'b0;
			samp_q  <= 1'b0;
			level_q <= 1'b0;
			edge_q  <= '0;
		end else if (clk_en) begin
			sync1_q <= pulse_input_pin; // R15
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pin_q   <= pin_d;
			phase_q <= phase_d;
			samp_q  <= samp_d;
			level_q <= level_d;
			edge_q  <= edge_d;
		end
	end

	assign edge_o = edge_q;

	AST_EDGE_QUALIFIED: assert property (@(posedge clk) disable iff (!reset_n) // R10
		edge_o.rise |-> level_q && samp_q)
		else $error("rise reported without two high samples");

	AST_EDGE_PULSE: assert property (@(posedge clk) disable iff (!reset_n) // R10
		(edge_o.rise || edge_o.fall) && clk_en |=> !(edge_o.rise || edge_o.fall))
		else $error("qualified edge reported for more than one cycle");

endmodule : pwc_edge_filter

/* File: logic/pwc_timer.sv */
/*
 * pwc_timer: 8-bit pulse width capture timer with control, counter and two captures.
 * Assumes a byte-wide processor memory port with byte and single-bit writes,
 * and an asynchronous pulse input pin.
 */
`timescale 1ns/1ns

// Overview of operation
// R1: a qualified rising edge copies the counter into rise_capture, held until next rise.
// R2: a qualified falling edge copies the counter into fall_capture, held until next fall.
// R3: reset clears both capture registers to zero.
// R4: reset or a cleared count enable forces the counter to zero.
// R5: reset clears count_control, disabling counting and selecting divide by 512.
// R6: control bit 7 enables counting; zero holds the counter cleared and stopped.
// R7: control bits 1:0 select main clock divided by 512, 256, 128 or 64.
// R8: software always writes zero to control bits 2 through 6.
// R9: the counter runs freely and wraps from ff to 00.
// R10: the pin is sampled every two count clocks; two equal samples qualify an edge.
// R11: the source holds each level for at least five count clocks.
// R12: pulses shorter than two count clocks cause no capture.
// R13: captures are read-only bytes, read whole by software.
// R14: count_control accepts both single-bit and byte writes.
// R15: the pin is synchronised; a capture loads the counter of the qualifying cycle.
module pwc_timer
	import pwc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	input  wire logic       pulse_input_pin,
	input  wire pwc_req_s   req,
	output logic [7:0]      rd_data_q,
	output logic            rd_valid_q,
	output logic [7:0]      rise_capture_q,
	output logic [7:0]      fall_capture_q,
	output logic [7:0]      free_counter_q,
	output logic            count_enable_bit_q
);

	logic [7:0] count_control_q;
	logic [7:0] count_control_d;
	logic [7:0] free_counter_d;
	logic [7:0] rise_capture_d;
	logic [7:0] fall_capture_d;
	logic [7:0] rd_data_d;
	logic       rd_valid_d;
	logic       count_tick;
	pwc_edge_s  edge_seen;

	// two qualified edges are at least two sampling periods apart
	localparam logic [2:0] EDGE_MIN_TICKS = 3'h4;
	localparam logic [2:0] GAP_FULL       = 3'h7;

	logic [2:0] edge_gap_q;
	logic [2:0] edge_gap_d;

	function automatic logic addr_hit(input pwc_req_s r, input logic [15:0] a);
		return r.addr == a;
	endfunction : addr_hit

	pwc_prescale #(
		.W               (DIV_W)
	) u_prescale (
		.clk             (clk),
		.reset_n         (reset_n),
		.clk_en          (clk_en),
		.sel             (count_control_q[SEL_HI_BIT:SEL_LO_BIT]),
		.tick            (count_tick)
	);

	pwc_edge_filter u_edge (
		.clk             (clk),
		.reset_n         (reset_n),
		.clk_en          (clk_en),
		.tick            (count_tick),
		.pulse_input_pin (pulse_input_pin),
		.edge_o          (edge_seen)
	);

	// control register: byte writes and single-bit writes
	always_comb begin
		count_control_d = count_control_q;
		if (req.wr && addr_hit(req, CTRL_ADDR)) begin // R14
			// reserved bits are kept at zero whatever is written
			count_control_d = req.wdata & CTRL_WMASK; // R8
		end else if (req.bit_wr && addr_hit(req, CTRL_ADDR)) begin // R14
			count_control_d[req.bit_idx] = req.bit_val;
			count_control_d = count_control_d & CTRL_WMASK;
		end
	end

	// free-running counter, cleared while disabled
	always_comb begin
		free_counter_d = free_counter_q;
		if (!count_control_q[CE_BIT]) begin // R4 R6
			free_counter_d = CNT_RESET;
		end else if (count_tick) begin // R6
			free_counter_d = free_counter_q + 8'h01; // R9
		end
	end

	// captures take the counter value of the qualifying cycle
	always_comb begin
		rise_capture_d = rise_capture_q;
		fall_capture_d = fall_capture_q;
		if (edge_seen.rise) begin // R1 R15
			rise_capture_d = free_counter_q;
		end
		if (edge_seen.fall) begin // R2 R15
			fall_capture_d = free_counter_q;
		end
	end

	// read port: answer one cycle after the request
	always_comb begin
		rd_valid_d = req.rd;
		rd_data_d  = UNMAPPED_DATA;
		if (req.rd) begin
			if (addr_hit(req, CTRL_ADDR)) begin
				rd_data_d = count_control_q;
			end else if (addr_hit(req, RISE_ADDR)) begin // R13
				rd_data_d = rise_capture_q;
			end else if (addr_hit(req, FALL_ADDR)) begin // R13
				rd_data_d = fall_capture_q;
			end else if (addr_hit(req, CNT_ADDR)) begin
				rd_data_d = free_counter_q;
			end else begin
				rd_data_d = UNMAPPED_DATA;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_control_q <= CTRL_RESET; // R5
			free_counter_q  <= CNT_RESET; // R4
		end else if (clk_en) begin
			count_control_q <= count_control_d;
			free_counter_q  <= free_counter_d;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rise_capture_q <= CAP_RESET; // R3
			fall_capture_q <= CAP_RESET; // R3
		end else if (clk_en) begin
			rise_capture_q <= rise_capture_d;
			fall_capture_q <= fall_capture_d;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_q          <= UNMAPPED_DATA;
			rd_valid_q         <= 1'b0;
			count_enable_bit_q <= 1'b0;
		end else if (clk_en) begin
			rd_data_q          <= rd_data_d;
			rd_valid_q         <= rd_valid_d;
			count_enable_bit_q <= count_control_d[CE_BIT];
		end
	end

	// count ticks since the last qualified edge, saturating; checking aid only
	always_comb begin
		edge_gap_d = edge_gap_q;
		if (edge_seen.rise || edge_seen.fall) begin
			edge_gap_d = 3'h0;
		end else if (count_tick && edge_gap_q != GAP_FULL) begin
			edge_gap_d = edge_gap_q + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			edge_gap_q <= GAP_FULL;
		end else if (clk_en) begin
			edge_gap_q <= edge_gap_d;
		end
	end

	AST_RISE_LOAD: assert property (@(posedge clk) disable iff (!reset_n) // R1
		edge_seen.rise && clk_en |=> rise_capture_q == $past(free_counter_q))
		else $error("rise capture did not take the counter value");

	AST_RISE_HOLD: assert property (@(posedge clk) disable iff (!reset_n) // R1
		!(edge_seen.rise && clk_en) |=> $stable(rise_capture_q))
		else $error("rise capture changed without a rising edge");

	AST_FALL_LOAD: assert property (@(posedge clk) disable iff (!reset_n) // R2
		edge_seen.fall && clk_en |=> fall_capture_q == $past(free_counter_q))
		else $error("fall capture did not take the counter value");

	AST_FALL_HOLD: assert property (@(posedge clk) disable iff (!reset_n) // R2
		!(edge_seen.fall && clk_en) |=> $stable(fall_capture_q))
		else $error("fall capture changed without a falling edge");

	AST_CNT_CLEARED: assert property (@(posedge clk) disable iff (!reset_n) // R4
		!count_control_q[CE_BIT] && clk_en |=> free_counter_q == CNT_RESET)
		else $error("counter not cleared while disabled");

	AST_CNT_STEP: assert property (@(posedge clk) disable iff (!reset_n) // R9
		count_control_q[CE_BIT] && count_tick && clk_en
		|=> free_counter_q == 8'($past(free_counter_q) + 8'h01))
		else $error("counter did not step by one on a count tick");

	AST_CNT_STILL: assert property (@(posedge clk) disable iff (!reset_n) // R6
		count_control_q[CE_BIT] && (!count_tick || !clk_en) |=> $stable(free_counter_q))
		else $error("counter moved without a count tick");

	AST_CTRL_BYTE: assert property (@(posedge clk) disable iff (!reset_n) // R14
		req.wr && req.addr == CTRL_ADDR && clk_en
		|=> count_control_q == ($past(req.wdata) & CTRL_WMASK))
		else $error("byte write to control not stored");

	AST_CTRL_BIT: assert property (@(posedge clk) disable iff (!reset_n) // R14
		!req.wr && req.bit_wr && req.addr == CTRL_ADDR && req.bit_idx == CE_BIT && clk_en
		|=> count_control_q[CE_BIT] == $past(req.bit_val))
		else $error("bit write to count enable not stored");

	AST_CTRL_RSV: assert property (@(posedge clk) disable iff (!reset_n) // R8
		count_control_q[6:2] == 5'h00)
		else $error("reserved control bits not zero");

	AST_RD_CAPTURE: assert property (@(posedge clk) disable iff (!reset_n) // R13
		req.rd && req.addr == RISE_ADDR && clk_en
		|=> rd_valid_q && rd_data_q == $past(rise_capture_q))
		else $error("rise capture read returned wrong data");

	AST_RD_RO: assert property (@(posedge clk) disable iff (!reset_n) // R13
		req.wr && req.addr == FALL_ADDR && !edge_seen.fall && clk_en
		|=> $stable(fall_capture_q))
		else $error("write altered a read-only capture");

	AST_EDGE_SPACING: assert property (@(posedge clk) disable iff (!reset_n) // R12
		(edge_seen.rise || edge_seen.fall) |-> edge_gap_q >= EDGE_MIN_TICKS)
		else $error("edges closer than two sampling periods");

	AST_RESET_STATE: assert property (@(posedge clk) // R3
		!reset_n ##1 !reset_n |-> rise_capture_q == CAP_RESET && fall_capture_q == CAP_RESET
			&& free_counter_q == CNT_RESET && count_control_q == CTRL_RESET
			&& !rd_valid_q && !count_enable_bit_q)
		else $error("state not cleared during reset");

	AST_RD_VALID: assert property (@(posedge clk) disable iff (!reset_n) // R13
		clk_en |=> rd_valid_q == $past(req.rd))
		else $error("read answer strobe does not follow the request");

	AST_RD_IDLE: assert property (@(posedge clk) disable iff (!reset_n) // R13
		!req.rd && clk_en |=> rd_data_q == UNMAPPED_DATA)
		else $error("read data not zero without a read");

	AST_RD_CTRL: assert property (@(posedge clk) disable iff (!reset_n) // R14
		req.rd && req.addr == CTRL_ADDR && clk_en
		|=> rd_valid_q && rd_data_q == $past(count_control_q))
		else $error("control read returned wrong data");

	AST_RD_FALL: assert property (@(posedge clk) disable iff (!reset_n) // R13
		req.rd && req.addr == FALL_ADDR && clk_en
		|=> rd_valid_q && rd_data_q == $past(fall_capture_q))
		else $error("fall capture read returned wrong data");

	AST_RD_CNT: assert property (@(posedge clk) disable iff (!reset_n) // R9
		req.rd && req.addr == CNT_ADDR && clk_en
		|=> rd_valid_q && rd_data_q == $past(free_counter_q))
		else $error("counter read returned wrong data");

	AST_RD_UNMAPPED: assert property (@(posedge clk) disable iff (!reset_n) // R13
		req.rd && req.addr != CTRL_ADDR && req.addr != RISE_ADDR && req.addr != FALL_ADDR
			&& req.addr != CNT_ADDR && clk_en
		|=> rd_valid_q && rd_data_q == UNMAPPED_DATA)
		else $error("unmapped read did not answer zero");

	AST_CE_MIRROR: assert property (@(posedge clk) disable iff (!reset_n) // R6
		count_enable_bit_q == count_control_q[CE_BIT])
		else $error("count enable output differs from control bit");

	AST_CTRL_HOLD: assert property (@(posedge clk) disable iff (!reset_n) // R14
		(!((req.wr || req.bit_wr) && req.addr == CTRL_ADDR) || !clk_en)
		|=> $stable(count_control_q))
		else $error("control changed without a write to it");

	AST_CTRL_BIT_RSV: assert property (@(posedge clk) disable iff (!reset_n) // R14
		!req.wr && req.bit_wr && req.addr == CTRL_ADDR && req.bit_idx >= 3'h2
			&& req.bit_idx <= 3'h6 && clk_en |=> $stable(count_control_q))
		else $error("bit write to a reserved control bit took effect");

	AST_CTRL_BIT_SEL: assert property (@(posedge clk) disable iff (!reset_n) // R14
		!req.wr && req.bit_wr && req.addr == CTRL_ADDR && req.bit_idx <= SEL_HI_BIT && clk_en
		|=> count_control_q[$past(req.bit_idx)] == $past(req.bit_val))
		else $error("bit write to clock select not stored");

	AST_FREEZE: assert property (@(posedge clk) disable iff (!reset_n) // R6
		!clk_en |=> $stable(free_counter_q) && $stable(rise_capture_q)
			&& $stable(fall_capture_q) && $stable(count_control_q) && $stable(rd_data_q))
		else $error("state moved while the clock enable was low");

	AST_CNT_WRAP: assert property (@(posedge clk) disable iff (!reset_n) // R9
		count_control_q[CE_BIT] && count_tick && clk_en && free_counter_q == 8'hff
		|=> free_counter_q == 8'h00)
		else $error("counter did not wrap from ff to 00");

	AST_CNT_START: assert property (@(posedge clk) disable iff (!reset_n) // R4
		$rose(count_control_q[CE_BIT]) |-> free_counter_q == CNT_RESET)
		else $error("counter not zero when counting is enabled");

endmodule : pwc_timer

/* File: dv/pwc_pulse_src.sv */
/*
 * pwc_pulse_src: model of the external pulse source on the pulse input pin.
 * Assumes the caller passes level lengths in main clocks.
 */
`timescale 1ns/1ns
module pwc_pulse_src (
	input  wire logic clk,
	output logic      pin
);
	initial pin = 1'b0;

	// pin moves on the falling clock edge, unrelated to sampling
	task automatic pulse(input int hi, input int lo);
		@(negedge clk);
		pin = 1'b1;
		repeat (hi) @(negedge clk);
		pin = 1'b0;
		repeat (lo) @(negedge clk);
	endtask : pulse
endmodule : pwc_pulse_src

/* File: dv/test_pulse_width_capture_timer.sv */
/*
 * test_pulse_width_capture_timer: random and corner tests of pwc_timer.
 * Assumes pwc_pulse_src drives the pulse input pin.
 */
`timescale 1ns/1ns
module test_pulse_width_capture_timer
	import pwc_pkg::*;
;
	logic        clk;
	logic        reset_n;
	logic        clk_en;
	logic        pin;
	pwc_req_s    req;
	logic [7:0]  rd_data;
	logic        rd_valid;
	logic [7:0]  rise_q;
	logic [7:0]  fall_q;
	logic [7:0]  cnt_q;
	logic        ce_q;
	int          n_errors;
	int          checked;
	logic [31:0] rs;
	logic [15:0] al [5] = '{CTRL_ADDR, RISE_ADDR, FALL_ADDR, CNT_ADDR, 16'h0000};

	initial clk = 1'b0;
	always #50 clk = ~clk;

	pwc_timer dut_u (
		.clk                (clk),
		.reset_n            (reset_n),
		.clk_en             (clk_en),
		.pulse_input_pin    (pin),
		.req                (req),
		.rd_data_q          (rd_data),
		.rd_valid_q         (rd_valid),
		.rise_capture_q     (rise_q),
		.fall_capture_q     (fall_q),
		.free_counter_q     (cnt_q),
		.count_enable_bit_q (ce_q)
	);

	pwc_pulse_src src_u (
		.clk (clk),
		.pin (pin)
	);

	function automatic logic [7:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs[7:0];
	endfunction : rnd

	task automatic end_of_test();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic bus(input logic r, input logic w, input logic b, input logic [15:0] a,
		input logic [7:0] d, input logic [2:0] bi);
		@(posedge clk);
		req <= '{rd: r, wr: w, bit_wr: b, addr: a, bit_idx: bi, bit_val: d[0], wdata: d};
		@(posedge clk);
		req <= '0;
		#1;
	endtask : bus

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		bus(1'b1, 1'b0, 1'b0, a, 8'h00, 3'h0);
		check("rd_valid", 16'(rd_valid), 16'h0001);
		check("rd_data", 16'(rd_data), 16'(exp));
	endtask : rd

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus(1'b0, 1'b1, 1'b0, a, d, 3'h0);
	endtask : wr

	task automatic bwr(input logic [2:0] bi, input logic v);
		bus(1'b0, 1'b0, 1'b1, CTRL_ADDR, {7'h00, v}, bi);
	endtask : bwr

	// cycles until the counter next changes
	task automatic gap(output int n);
		logic [7:0] o;
		o = cnt_q;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (cnt_q === o && n < 2000);
	endtask : gap

	initial begin
		logic [7:0] v;
		logic [7:0] r;
		logic [7:0] f;
		int         n;
		int         hi;
		int         lo;
		clk_en = 1'b1;
		reset_n = 1'b0;
		req = '0;
		n_errors = 0;
		checked = 0;
		rs = 32'h7cc1;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		foreach (al[i]) rd(al[i], 8'h00);
		repeat (4) begin
			v = rnd() & CTRL_WMASK;
			wr(CTRL_ADDR, v);
			rd(CTRL_ADDR, v);
		end
		wr(CTRL_ADDR, 8'h00);
		bwr(3'h7, 1'b1);
		bwr(3'h0, 1'b1);
		bwr(3'h1, 1'b1);
		rd(CTRL_ADDR, 8'h83);
		bwr(3'h4, 1'b1);
		rd(CTRL_ADDR, 8'h83);
		bus(1'b0, 1'b1, 1'b1, CTRL_ADDR, 8'h01, 3'h7);
		rd(CTRL_ADDR, 8'h01);
		wr(RISE_ADDR, 8'h5a);
		rd(RISE_ADDR, 8'h00);
		wr(FALL_ADDR, 8'ha5);
		wr(CNT_ADDR, 8'h3c);
		rd(FALL_ADDR, 8'h00);
		rd(CNT_ADDR, 8'h00);
		for (int s = 0; s < 4; s++) begin
			wr(CTRL_ADDR, 8'h80 | 8'(s));
			check("enable", 16'(ce_q), 16'h0001);
			gap(n);
			v = cnt_q;
			gap(n);
			check("tick gap", 16'(n), 16'(512 >> s));
			check("step", 16'(cnt_q), 16'(8'(v + 8'h01)));
		end
		n = 0;
		while (cnt_q !== 8'hff && n < 20000) begin
			@(posedge clk);
			#1;
			n++;
		end
		gap(n);
		check("wrap", 16'(cnt_q), 16'h0000);
		@(posedge clk);
		clk_en <= 1'b0;
		#1;
		v = cnt_q;
		repeat (300) @(posedge clk);
		#1;
		check("freeze", 16'(cnt_q), 16'(v));
		@(posedge clk);
		clk_en <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			hi = 5 + int'(rnd() % 32);
			lo = 8 + int'(rnd() % 16);
			src_u.pulse(hi * 64, lo * 64);
			r = rise_q;
			f = fall_q;
			v = f - r;
			check("width", 16'(int'(v) >= hi - 2 && int'(v) <= hi + 2), 16'h0001);
		end
		src_u.pulse(64, 640);
		check("noise rise", 16'(rise_q), 16'(r));
		check("noise fall", 16'(fall_q), 16'(f));
		bwr(3'h7, 1'b0);
		repeat (2) @(posedge clk);
		#1;
		check("stopped", 16'(cnt_q), 16'h0000);
		rd(CTRL_ADDR, 8'h03);
		@(posedge clk);
		reset_n <= 1'b0;
		#1;
		check("reset caps", 16'({rise_q, fall_q}), 16'h0000);
		check("reset cnt", 16'({cnt_q, 7'h00, ce_q}), 16'h0000);
		@(posedge clk);
		reset_n <= 1'b1;
		rd(CTRL_ADDR, 8'h00);
		end_of_test();
	end

	initial begin
		repeat (90000) @(posedge clk);
		n_errors++;
		end_of_test();
	end
endmodule : test_pulse_width_capture_timer
